// File: rtl/otfm_pkg.sv
package otfm_pkg;
    localparam int OTFM_CLK_HZ = 250000000;
    localparam logic [5:0] OTFM_CODE_NONE = 6'h00;
    localparam logic [5:0] OTFM_CODE_RUN = 6'h01;
    localparam logic [5:0] OTFM_CODE_FAULT = 6'h02;
    localparam logic [5:0] OTFM_CODE_FDT1 = 6'h03;
    localparam logic [5:0] OTFM_CODE_FAR = 6'h04;
    localparam logic [5:0] OTFM_CODE_ZERO = 6'h05;
    localparam logic [5:0] OTFM_CODE_MOL = 6'h06;
    localparam logic [5:0] OTFM_CODE_DOL = 6'h07;
    localparam logic [5:0] OTFM_CODE_CNT_SET = 6'h08;
    localparam logic [5:0] OTFM_CODE_CNT_SPEC = 6'h09;
    localparam logic [5:0] OTFM_CODE_LEN = 6'h0A;
    localparam logic [5:0] OTFM_CODE_SEQ = 6'h0B;
    localparam logic [5:0] OTFM_CODE_RTIME = 6'h0C;
    localparam logic [5:0] OTFM_CODE_FLIM = 6'h0D;
    localparam logic [5:0] OTFM_CODE_TLIM = 6'h0E;
    localparam logic [5:0] OTFM_CODE_READY = 6'h0F;
    localparam logic [5:0] OTFM_CODE_AI = 6'h10;
    localparam logic [5:0] OTFM_CODE_UPPER = 6'h11;
    localparam logic [5:0] OTFM_CODE_LOWER = 6'h12;
    localparam logic [5:0] OTFM_OC_MAX = 6'h26;
    localparam logic [5:0] OTFM_RELAY_MAX = 6'h24;
    localparam logic [5:0] OTFM_OC_RST = 6'h00;
    localparam logic [5:0] OTFM_RELAY_RST = 6'h02;
    localparam logic [5:0] OTFM_PULSE_FN_RST = 6'h00;
    localparam logic OTFM_MODE_PULSE = 1'b0;
    localparam logic OTFM_MODE_RST = 1'b0;
    // Frequencies in units of 10 Hz (0.01 kHz)
    localparam logic [15:0] OTFM_FREQ_MIN = 16'h0001;
    localparam logic [15:0] OTFM_FREQ_MAX = 16'h2710;
    localparam logic [15:0] OTFM_FREQ_RST = 16'h0BB8;
    localparam int OTFM_PULSE_MS = 250;
    localparam int OTFM_PULSE_CYC = OTFM_PULSE_MS * (OTFM_CLK_HZ / 1000);
    // Wishbone map, byte addresses
    localparam logic [3:0] OTFM_REG_MODE = 4'h0;
    localparam logic [3:0] OTFM_REG_OC_SEL = 4'h4;
    localparam logic [3:0] OTFM_REG_RELAY_SEL = 4'h8;
    localparam logic [3:0] OTFM_REG_PULSE_CFG = 4'hC;
    localparam logic [15:0] OTFM_PHASE_STEP = 16'h000A;
    // Accumulator wrap for one toggle: f units of 10 Hz give 20*f toggles per second
    localparam logic [31:0] OTFM_ACC_WRAP = 32'(OTFM_CLK_HZ / 20);
endpackage : otfm_pkg

// File: rtl/otfm_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Mux terminal mode: pulse (default) or switch
// - Pulse frequency never above 100 kHz
// - Open-collector selector 0..38, resets to 0
// - Relay selector 0..36, resets to 2
// - Code 0 keeps output inactive
// - Code 1 on while running
// - Code 2 on at stopping fault
// - Codes 3,4 follow level and arrival flags
// - Code 5 running at zero frequency only
// - Code 6 motor overload pre-alarm
// - Code 7 drive overload ten seconds ahead
// - Codes 8,9 count values reached
// - Code 10 actual length exceeds target
// - Code 11 single 250 ms pulse per cycle
// - Code 12 running time exceeds threshold
// - Code 13 set and output frequency limited
// - Code 14 speed mode, torque limit, stall
// - Code 15 supplies stable, no fault, ready
// - Code 16 first analog above second
// - Codes 17,18 upper/lower limit, lower off stopped
// - Pulse span 0.01 kHz to set maximum
module otfm_mux
    import otfm_pkg::*;
#(
    parameter int SEQ_PULSE_CYC = OTFM_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic running_i,
    input wire logic fault_stop_i,
    input wire logic freq_level_i,
    input wire logic freq_arrival_i,
    input wire logic out_freq_zero_i,
    input wire logic motor_prealarm_i,
    input wire logic drive_prealarm_i,
    input wire logic set_count_reached_i,
    input wire logic specified_count_reached_i,
    input wire logic length_reached_i,
    input wire logic seq_cycle_done_i,
    input wire logic run_time_reached_i,
    input wire logic set_freq_beyond_limit_i,
    input wire logic out_freq_at_limit_i,
    input wire logic speed_control_i,
    input wire logic torque_at_limit_i,
    input wire logic stall_protect_i,
    input wire logic supplies_stable_i,
    input wire logic run_ready_i,
    input wire logic [15:0] analog_input_first_i,
    input wire logic [15:0] analog_input_second_i,
    input wire logic at_upper_limit_i,
    input wire logic at_lower_limit_i,
    input wire logic [15:0] pulse_freq_req_i,
    output logic oc_output_o,
    output logic relay_contacts_o,
    output logic multiplexed_output_terminal_o
);
    logic mux_terminal_mode_select_r;
    logic [5:0] oc_output_function_select_r;
    logic [5:0] relay_function_select_r;
    logic [5:0] pulse_output_function_select_r;
    logic [15:0] pulse_output_max_freq_r;
    logic ack_r;
    logic [31:0] rdat_r;
    logic seq_done_d_r;
    logic [31:0] seq_cnt_r;
    logic seq_pulse;
    logic pulse_out_r;
    logic oc_r;
    logic relay_r;
    logic mux_r;
    logic [15:0] freq_eff;
    logic wr;

    // Write lands on the edge where the master samples ack, never earlier
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

    function automatic logic cond_sel(input logic [5:0] code, input logic [5:0] max);
        logic v;
        v = 1'b0;
        if (code <= max) begin
            unique case (code)
                OTFM_CODE_RUN: v = running_i;
                OTFM_CODE_FAULT: v = fault_stop_i;
                OTFM_CODE_FDT1: v = freq_level_i;
                OTFM_CODE_FAR: v = freq_arrival_i;
                OTFM_CODE_ZERO: v = running_i && out_freq_zero_i;
                OTFM_CODE_MOL: v = motor_prealarm_i;
                OTFM_CODE_DOL: v = drive_prealarm_i;
                OTFM_CODE_CNT_SET: v = set_count_reached_i;
                OTFM_CODE_CNT_SPEC: v = specified_count_reached_i;
                OTFM_CODE_LEN: v = length_reached_i;
                OTFM_CODE_SEQ: v = seq_pulse;
                OTFM_CODE_RTIME: v = run_time_reached_i;
                OTFM_CODE_FLIM: v = set_freq_beyond_limit_i && out_freq_at_limit_i;
                OTFM_CODE_TLIM: v = speed_control_i && torque_at_limit_i && stall_protect_i;
                OTFM_CODE_READY: v = supplies_stable_i && !fault_stop_i && run_ready_i;
                OTFM_CODE_AI: v = analog_input_first_i > analog_input_second_i;
                OTFM_CODE_UPPER: v = at_upper_limit_i;
                OTFM_CODE_LOWER: v = running_i && at_lower_limit_i;
                default: v = 1'b0;
            endcase
        end
        return v;
    endfunction : cond_sel

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_terminal_mode_select_r <= OTFM_MODE_RST;
            oc_output_function_select_r <= OTFM_OC_RST;
            relay_function_select_r <= OTFM_RELAY_RST;
            pulse_output_function_select_r <= OTFM_PULSE_FN_RST;
            pulse_output_max_freq_r <= OTFM_FREQ_RST;
        end else if (wr) begin
            unique case (wb_adr_i)
                OTFM_REG_MODE: mux_terminal_mode_select_r <= wb_dat_i[0];
                OTFM_REG_OC_SEL: oc_output_function_select_r <= wb_dat_i[5:0];
                OTFM_REG_RELAY_SEL: relay_function_select_r <= wb_dat_i[5:0];
                OTFM_REG_PULSE_CFG: begin
                    pulse_output_function_select_r <= wb_dat_i[21:16];
                    if (wb_dat_i[15:0] > OTFM_FREQ_MAX) begin
                        pulse_output_max_freq_r <= OTFM_FREQ_MAX;
                    end else if (wb_dat_i[15:0] < OTFM_FREQ_MIN) begin
                        pulse_output_max_freq_r <= OTFM_FREQ_MIN;
                    end else begin
                        pulse_output_max_freq_r <= wb_dat_i[15:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
            unique case (wb_adr_i)
                OTFM_REG_MODE: rdat_r <= {28'h0, relay_r, oc_r, mux_r, mux_terminal_mode_select_r};
                OTFM_REG_OC_SEL: rdat_r <= {26'h0, oc_output_function_select_r};
                OTFM_REG_RELAY_SEL: rdat_r <= {26'h0, relay_function_select_r};
                OTFM_REG_PULSE_CFG: rdat_r <= {10'h0, pulse_output_function_select_r,
                    pulse_output_max_freq_r};
                default: rdat_r <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Retriggers on a new cycle end so back-to-back cycles merge into one long pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_done_d_r <= 1'b0;
            seq_cnt_r <= 32'h0000_0000;
        end else begin
            seq_done_d_r <= seq_cycle_done_i;
            if (seq_cycle_done_i && !seq_done_d_r) begin
                seq_cnt_r <= 32'(SEQ_PULSE_CYC);
            end else if (seq_cnt_r != 32'h0000_0000) begin
                seq_cnt_r <= seq_cnt_r - 32'h0000_0001;
            end
        end
    end
    assign seq_pulse = seq_cnt_r != 32'h0000_0000;

    // Requested frequency clamped to the span; phase accumulator gives 50 percent duty
    always_comb begin
        freq_eff = pulse_freq_req_i;
        if (freq_eff > pulse_output_max_freq_r) begin
            freq_eff = pulse_output_max_freq_r;
        end
        if (freq_eff < OTFM_FREQ_MIN) begin
            freq_eff = OTFM_FREQ_MIN;
        end
    end

    // One toggle per accumulator wrap; the clamp above keeps the rate under the ceiling
    logic [31:0] acc_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= 32'h0000_0000;
            pulse_out_r <= 1'b0;
        end else if (mux_terminal_mode_select_r != OTFM_MODE_PULSE) begin
            acc_r <= 32'h0000_0000;
            pulse_out_r <= 1'b0;
        end else if (acc_r + {16'h0, freq_eff} >= OTFM_ACC_WRAP) begin
            acc_r <= acc_r + {16'h0, freq_eff} - OTFM_ACC_WRAP;
            pulse_out_r <= !pulse_out_r;
        end else begin
            acc_r <= acc_r + {16'h0, freq_eff};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_r <= 1'b0;
            relay_r <= 1'b0;
            mux_r <= 1'b0;
        end else begin
            oc_r <= cond_sel(oc_output_function_select_r, OTFM_OC_MAX);
            relay_r <= cond_sel(relay_function_select_r, OTFM_RELAY_MAX);
            if (mux_terminal_mode_select_r == OTFM_MODE_PULSE) begin
                mux_r <= pulse_out_r;
            end else begin
                mux_r <= cond_sel(pulse_output_function_select_r, OTFM_OC_MAX);
            end
        end
    end
    assign oc_output_o = oc_r;
    assign relay_contacts_o = relay_r;
    assign multiplexed_output_terminal_o = mux_r;
endmodule : otfm_mux
`default_nettype wire

// File: bench/otfm_load.sv
`timescale 1ns/1ps
`default_nettype none
// Load on the multiplexed terminal; counts switching edges so the pulse rate can be judged
module otfm_load (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic drive_i,
    output logic [15:0] edges_o
);
    logic last_r;
    always_ff @(posedge clk_i) begin
        last_r <= drive_i;
        if (clr_i) begin
            edges_o <= 16'h0000;
        end else if (drive_i != last_r) begin
            edges_o <= edges_o + 16'h0001;
        end
    end
endmodule : otfm_load
`default_nettype wire

// File: bench/otfm_mux_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module otfm_mux_asserts
    import otfm_pkg::*;
#(
    parameter int SEQ_PULSE_CYC = OTFM_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic running_i,
    input wire logic fault_stop_i,
    input wire logic seq_cycle_done_i,
    input wire logic [15:0] analog_input_first_i,
    input wire logic [15:0] analog_input_second_i,
    input wire logic oc_output_o,
    input wire logic relay_contacts_o,
    input wire logic multiplexed_output_terminal_o
);
    // Selectors are not ports, so shadow them from bus writes
    logic [5:0] oc_r;
    logic [5:0] rl_r;
    logic wr;
    assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_r <= OTFM_OC_RST;
            rl_r <= OTFM_RELAY_RST;
        end else if (wr && wb_adr_i == OTFM_REG_OC_SEL) begin
            oc_r <= wb_dat_i[5:0];
        end else if (wr && wb_adr_i == OTFM_REG_RELAY_SEL) begin
            rl_r <= wb_dat_i[5:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_reset_quiet:
        assert property (disable iff (1'b0) rst_i |=> !oc_output_o && !relay_contacts_o
            && !multiplexed_output_terminal_o && !wb_ack_o) else $error("output active in reset");
    a_ack_follows:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_ack_single:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
    a_oc_none:
        assert property (oc_r == OTFM_CODE_NONE |=> !oc_output_o) else $error("code 0 active");
    a_oc_running:
        assert property (oc_r == OTFM_CODE_RUN |=> oc_output_o == $past(running_i))
            else $error("run code mismatch");
    a_zero_stopped:
        assert property (oc_r == OTFM_CODE_ZERO && !running_i |=> !oc_output_o)
            else $error("zero speed on while stopped");
    a_relay_fault:
        assert property (rl_r == OTFM_CODE_FAULT |=> relay_contacts_o == $past(fault_stop_i))
            else $error("fault code mismatch");
    a_relay_reserved:
        assert property (rl_r > OTFM_CODE_LOWER |=> !relay_contacts_o)
            else $error("reserved code active");
    a_analog_equal:
        assert property (oc_r == OTFM_CODE_AI && analog_input_first_i == analog_input_second_i
            |=> !oc_output_o) else $error("equal analog gave on");
    a_seq_pulse:
        assert property ($rose(seq_cycle_done_i) && oc_r == OTFM_CODE_SEQ |-> ##[1:3] oc_output_o [*8])
            else $error("cycle pulse missing");
    c_seq: cover property ($rose(seq_cycle_done_i) && oc_r == OTFM_CODE_SEQ);
    c_reserved: cover property (rl_r > OTFM_CODE_LOWER && fault_stop_i);
    c_write: cover property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o ##1 wr);
endmodule : otfm_mux_asserts
bind otfm_mux otfm_mux_asserts #(.SEQ_PULSE_CYC(SEQ_PULSE_CYC)) u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .running_i(running_i),
    .fault_stop_i(fault_stop_i),
    .seq_cycle_done_i(seq_cycle_done_i),
    .analog_input_first_i(analog_input_first_i),
    .analog_input_second_i(analog_input_second_i),
    .oc_output_o(oc_output_o),
    .relay_contacts_o(relay_contacts_o),
    .multiplexed_output_terminal_o(multiplexed_output_terminal_o)
);
`default_nettype wire

// File: bench/test_otfm_mux.sv
`timescale 1ns/1ps
`default_nettype none
module test_otfm_mux
    import otfm_pkg::*;
;
    // Short cycle pulse keeps the run brief
    localparam int SEQ = 20;
    localparam logic [20:0] NEED [0:18] = '{21'h0, 21'h1, 21'h2, 21'h4, 21'h8, 21'h11, 21'h20,
        21'h40, 21'h80, 21'h100, 21'h200, 21'h0, 21'h800, 21'h3000, 21'h1C000, 21'h60000, 21'h0,
        21'h80000, 21'h100001};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic ack;
    logic [20:0] st = 21'h0;
    logic [15:0] an1 = 16'h0;
    logic [15:0] an2 = 16'h0;
    logic [15:0] freq = 16'h0;
    logic lclr = 1'b1;
    logic oc, rly, mux;
    logic [15:0] edges;
    int fails = 0;
    int samples_checked = 0;
    otfm_mux #(.SEQ_PULSE_CYC(SEQ)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .running_i(st[0]), .fault_stop_i(st[1]), .freq_level_i(st[2]), .freq_arrival_i(st[3]),
        .out_freq_zero_i(st[4]), .motor_prealarm_i(st[5]), .drive_prealarm_i(st[6]),
        .set_count_reached_i(st[7]), .specified_count_reached_i(st[8]),
        .length_reached_i(st[9]), .seq_cycle_done_i(st[10]), .run_time_reached_i(st[11]),
        .set_freq_beyond_limit_i(st[12]), .out_freq_at_limit_i(st[13]),
        .speed_control_i(st[14]), .torque_at_limit_i(st[15]), .stall_protect_i(st[16]),
        .supplies_stable_i(st[17]), .run_ready_i(st[18]), .analog_input_first_i(an1),
        .analog_input_second_i(an2), .at_upper_limit_i(st[19]), .at_lower_limit_i(st[20]),
        .pulse_freq_req_i(freq), .oc_output_o(oc), .relay_contacts_o(rly),
        .multiplexed_output_terminal_o(mux));
    otfm_load u_load (.clk_i(clk_i), .clr_i(lclr), .drive_i(mux), .edges_o(edges));
    initial forever #2 clk_i = ~clk_i;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Called just after a rising edge; holds the cycle until ack is sampled
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        chk(q & m, e);
    endtask : rd
    task automatic sel(input logic [5:0] c);
        logic [31:0] q;
        wb(OTFM_REG_OC_SEL, 1'b1, {26'h0, c}, q);
        wb(OTFM_REG_RELAY_SEL, 1'b1, {26'h0, c}, q);
        wb(OTFM_REG_PULSE_CFG, 1'b1, {10'h0, c, 16'h2710}, q);
        tick(3);
    endtask : sel
    task automatic t_regs;
        logic [31:0] q;
        rd(OTFM_REG_MODE, 32'h1, 32'h0);
        rd(OTFM_REG_OC_SEL, 32'hFFFFFFFF, 32'h0);
        rd(OTFM_REG_RELAY_SEL, 32'hFFFFFFFF, 32'h2);
        rd(OTFM_REG_PULSE_CFG, 32'hFFFFFFFF, 32'h00000BB8);
        wb(4'h2, 1'b1, 32'hFFFFFFFF, q);
        rd(4'h2, 32'hFFFFFFFF, 32'h0);
        wb(OTFM_REG_OC_SEL, 1'b1, 32'h3F, q);
        rd(OTFM_REG_OC_SEL, 32'hFFFFFFFF, 32'h3F);
        $display("t_regs done");
    endtask : t_regs
    // Oversized request and limit must both clamp to the 100 kHz ceiling
    task automatic t_pulse;
        logic [31:0] q;
        freq <= 16'hFFFF;
        wb(OTFM_REG_PULSE_CFG, 1'b1, 32'h0000FFFF, q);
        tick(10);
        lclr <= 1'b0;
        tick(12500);
        chk({31'h0, edges >= 16'h9 && edges <= 16'hB}, 32'h1);
        $display("t_pulse done");
    endtask : t_pulse
    task automatic t_codes;
        logic [31:0] q;
        wb(OTFM_REG_MODE, 1'b1, 32'h1, q);
        for (int i = 1; i < 19; i++) begin
            if (i == 11 || i == 16) continue;
            sel(6'(i));
            st <= NEED[i];
            tick(3);
            chk({29'h0, oc, rly, mux}, 32'h7);
            st <= NEED[i] & (NEED[i] - 21'h1);
            tick(3);
            chk({29'h0, oc, rly, mux}, 32'h0);
        end
        $display("t_codes done");
    endtask : t_codes
    task automatic t_reserved;
        logic [5:0] c [0:4] = '{6'h00, 6'h13, 6'h24, 6'h26, 6'h3F};
        st <= 21'h1FFBFF;
        an1 <= 16'hFFFF;
        for (int i = 0; i < 5; i++) begin
            sel(c[i]);
            chk({29'h0, oc, rly, mux}, 32'h0);
        end
        st <= 21'h0;
        an1 <= 16'h0005;
        an2 <= 16'h0005;
        sel(OTFM_CODE_AI);
        chk({29'h0, oc, rly, mux}, 32'h0);
        an1 <= 16'h0006;
        tick(3);
        chk({29'h0, oc, rly, mux}, 32'h7);
        $display("t_reserved done");
    endtask : t_reserved
    task automatic t_seq;
        int n;
        n = 0;
        sel(OTFM_CODE_SEQ);
        st <= 21'h400;
        repeat (40) begin
            @(posedge clk_i);
            if (oc === 1'b1) n++;
        end
        chk(32'(n), 32'(SEQ));
        st <= 21'h0;
        $display("t_seq done");
    endtask : t_seq
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    initial begin
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        t_regs();
        t_pulse();
        t_codes();
        t_reserved();
        t_seq();
        give_verdict();
    end
endmodule : test_otfm_mux
`default_nettype wire
